// [rtl/sdsu_ahb_front.sv]
`timescale 1ns/1ps
`default_nettype none
module sdsu_ahb_front (
  input wire logic core_clk_in, // Core clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic hsel_in, // Slave select
  input wire logic [31:0] haddr_in, // Byte address
  input wire logic [1:0] htrans_in, // Transfer type
  input wire logic hwrite_in, // Write when high
  input wire logic [2:0] hsize_in, // Word only
  input wire logic [31:0] hwdata_in, // Write data
  input wire logic hready_in, // Bus ready
  output logic [31:0] hrdata_out, // Read data
  output logic hreadyout_out, // Slave ready
  output logic hresp_out, // Always OKAY
  sdsu_reg_if.front reg_bus // To register file
);
  typedef struct packed {
    sdsu_pkg::sdsu_bus_e state;
    logic [31:0] addr;
    logic [31:0] hrdata;
    logic hreadyout;
  } sdsu_front_s;

  sdsu_front_s r;
  sdsu_front_s n;
  logic addr_phase;

  // Only word transfers are issued, so hsize is not decoded
  assign addr_phase = hsel_in && hready_in && (htrans_in == sdsu_pkg::HTRANS_NONSEQ);
  assign reg_bus.wr_en = (r.state == sdsu_pkg::BUS_WRITE);
  assign reg_bus.addr = r.addr;
  assign reg_bus.wdata = hwdata_in;
  assign hrdata_out = r.hrdata;
  assign hreadyout_out = r.hreadyout;
  assign hresp_out = 1'b0;

  // Reads take one wait state so a write just before them is always seen
  always_comb begin
    n = r;
    unique case (r.state)
      sdsu_pkg::BUS_IDLE, sdsu_pkg::BUS_WRITE: begin
        n.state = sdsu_pkg::BUS_IDLE;
        if (addr_phase) begin
          n.addr = haddr_in;
          if (hwrite_in) begin
            n.state = sdsu_pkg::BUS_WRITE;
          end else begin
            n.state = sdsu_pkg::BUS_READ;
            n.hreadyout = 1'b0;
          end
        end
      end
      sdsu_pkg::BUS_READ: begin
        n.hrdata = reg_bus.rdata;
        n.hreadyout = 1'b1;
        n.state = sdsu_pkg::BUS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r.state <= sdsu_pkg::BUS_IDLE;
      r.addr <= sdsu_pkg::WORD_ZERO;
      r.hrdata <= sdsu_pkg::WORD_ZERO;
      r.hreadyout <= 1'b1;
    end else begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// [rtl/sdsu_pkg.sv]
package sdsu_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [31:0] OFS_STATUS = 32'h0000_0000;
  localparam logic [31:0] OFS_CTRL = 32'h0000_0004;
  localparam logic [31:0] OFS_ENGINE = 32'h0000_0008;

  // Status word: upper half of descriptor word three, bit 0 here is bit 32 there
  localparam int ST_ACTIVE = 31;
  localparam int ST_HALT = 30;
  localparam int ST_BABBLE = 29;
  localparam int ST_XACT_ERR = 28;
  localparam int ST_PHASE = 27;
  localparam int ST_TOGGLE = 25;
  localparam int ST_ERR_LSB = 23;
  localparam int ST_NAK_LSB = 19;
  localparam int ST_BYTES_LSB = 0;

  // Control word
  localparam int CT_VALID = 0;
  localparam int CT_RELOAD_LSB = 1;

  // Engine status word
  localparam int EN_RETRY_FIRST = 0;
  localparam int EN_RESULT_LSB = 1;
  localparam int EN_DONE = 4;

  // Field widths and constants
  localparam int ERR_W = 2;
  localparam int NAK_W = 4;
  localparam int BYTES_W = 15;
  localparam logic [1:0] ERR_RELOAD = 2'h3;
  localparam logic [1:0] ERR_ONE = 2'h1;
  localparam logic [1:0] ERR_ZERO = 2'h0;
  localparam logic [3:0] NAK_ONE = 4'h1;
  localparam logic [3:0] NAK_ZERO = 4'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Outcome of one split attempt, as reported by the transaction engine
  typedef enum logic [2:0] {
    RES_ACK = 3'h0,
    RES_NAK = 3'h1,
    RES_NYET = 3'h2,
    RES_ERR = 3'h3,
    RES_BABBLE = 3'h4
  } sdsu_result_e;

  // Front end bus states
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ = 3'b100
  } sdsu_bus_e;
endpackage

// [rtl/sdsu_reg_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Register access path between the bus front end and the descriptor logic
interface sdsu_reg_if;
  logic wr_en;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport front (output wr_en, output addr, output wdata, input rdata);
  modport core (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// [rtl/sdsu_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sdsu_top (
  input wire logic core_clk_in, // Core clock, 40 MHz
  input wire logic rst_n_in, // Async reset, active low
  // Register bus, AHB-Lite slave, word access only
  input wire logic hsel_in, // AHB slave select
  input wire logic [31:0] haddr_in, // AHB address
  input wire logic [1:0] htrans_in, // AHB transfer type
  input wire logic hwrite_in, // AHB write
  input wire logic [2:0] hsize_in, // AHB size
  input wire logic [31:0] hwdata_in, // AHB write data
  input wire logic hready_in, // AHB ready
  output logic [31:0] hrdata_out, // AHB read data
  output logic hreadyout_out, // AHB slave ready
  output logic hresp_out, // AHB response
  // Outcome of each split attempt, from the transaction engine on this clock
  input wire logic split_result_valid_in, // One split attempt finished, pulse
  input wire logic [2:0] split_result_code_in, // Outcome of that attempt
  input wire logic [14:0] split_result_bytes_in, // Bytes moved by that attempt
  input wire logic split_iso_in, // Attempt was isochronous
  input wire logic time_short_in, // Too little frame time left to retry
  // Frame timing
  input wire logic sof_in, // Start of frame, pulse
  // Descriptor state toward the scheduler
  output logic desc_active_out, // Descriptor active flag
  output logic desc_valid_out, // Descriptor valid flag
  output logic split_phase_out, // Zero start split, one complete split
  output logic toggle_out, // Current data toggle
  output logic retry_first_out // Hold aperiodic pointer, retry first after SOF
);
  // All descriptor state in one record, registered in one place
  typedef struct packed {
    // Status half of descriptor word three, written by both sides
    logic active;
    logic halt;
    logic babble;
    logic xact_err;
    logic split_phase_bit;
    logic toggle_bit;
    logic [1:0] err_count;
    logic [3:0] nak_retry_count;
    logic [14:0] transferred_byte_count;

    // Control word, written by software; hardware clears valid when it retires a descriptor
    logic valid;
    logic [3:0] nak_reload_value;

    // Engine bookkeeping, local to this block
    logic retry_first;
    logic [2:0] last_result;
    logic done;
  } sdsu_desc_s;

  // Descriptor state and its next value
  sdsu_desc_s r;
  sdsu_desc_s n;

  // Carrier to the bus front end
  sdsu_reg_if reg_bus ();

  // Split outcome qualified by the descriptor state
  logic live_evt;
  logic failed_evt;

  // Register images as software reads them
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [31:0] engine_word;

  // Bus front end; reads take one wait state, writes none
  sdsu_ahb_front u_front (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hwdata_in(hwdata_in),
    .hready_in(hready_in),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .reg_bus(reg_bus)
  );

  // Register images, reserved bits read zero
  always_comb begin
    // Status word, bit 0 here is bit 32 of the descriptor word
    status_word = sdsu_pkg::WORD_ZERO;
    status_word[sdsu_pkg::ST_ACTIVE] = r.active;
    status_word[sdsu_pkg::ST_HALT] = r.halt;
    status_word[sdsu_pkg::ST_BABBLE] = r.babble;
    status_word[sdsu_pkg::ST_XACT_ERR] = r.xact_err;
    status_word[sdsu_pkg::ST_PHASE] = r.split_phase_bit;
    status_word[sdsu_pkg::ST_TOGGLE] = r.toggle_bit;
    // Retry budgets and byte count
    status_word[sdsu_pkg::ST_ERR_LSB +: sdsu_pkg::ERR_W] = r.err_count;
    status_word[sdsu_pkg::ST_NAK_LSB +: sdsu_pkg::NAK_W] = r.nak_retry_count;
    status_word[sdsu_pkg::ST_BYTES_LSB +: sdsu_pkg::BYTES_W] = r.transferred_byte_count;

    // Control word
    ctrl_word = sdsu_pkg::WORD_ZERO;
    ctrl_word[sdsu_pkg::CT_VALID] = r.valid;
    ctrl_word[sdsu_pkg::CT_RELOAD_LSB +: sdsu_pkg::NAK_W] = r.nak_reload_value;

    // Engine word, read-only apart from the write-one-clear hold
    engine_word = sdsu_pkg::WORD_ZERO;
    engine_word[sdsu_pkg::EN_RETRY_FIRST] = r.retry_first;
    engine_word[sdsu_pkg::EN_RESULT_LSB +: 3] = r.last_result;
    engine_word[sdsu_pkg::EN_DONE] = r.done;
  end

  // Read mux; unmapped addresses read zero and still answer OKAY
  always_comb begin
    unique case (reg_bus.addr)
      sdsu_pkg::OFS_STATUS: reg_bus.rdata = status_word;
      sdsu_pkg::OFS_CTRL: reg_bus.rdata = ctrl_word;
      sdsu_pkg::OFS_ENGINE: reg_bus.rdata = engine_word;
      default: reg_bus.rdata = sdsu_pkg::WORD_ZERO;
    endcase
  end

  // Events only touch a descriptor that is both valid and active
  // A retired descriptor may still see a late result; it must not revive it
  assign live_evt = split_result_valid_in && r.valid && r.active;
  // Anything but ACK is a failed attempt that may need a retry slot
  assign failed_evt = live_evt && (split_result_code_in != sdsu_pkg::RES_ACK);

  // Software write first, then the hardware outcome on top of it, so an
  // outcome in the same cycle as a write is never lost
  always_comb begin
    n = r;

    // Software side of the descriptor
    if (reg_bus.wr_en) begin
      unique case (reg_bus.addr)
        // Software loads the starting state; the phase must be written zero
        sdsu_pkg::OFS_STATUS: begin
          n.active = reg_bus.wdata[sdsu_pkg::ST_ACTIVE];
          n.halt = reg_bus.wdata[sdsu_pkg::ST_HALT];
          n.babble = reg_bus.wdata[sdsu_pkg::ST_BABBLE];
          n.xact_err = reg_bus.wdata[sdsu_pkg::ST_XACT_ERR];
          n.split_phase_bit = reg_bus.wdata[sdsu_pkg::ST_PHASE];
          n.toggle_bit = reg_bus.wdata[sdsu_pkg::ST_TOGGLE];
          n.err_count = reg_bus.wdata[sdsu_pkg::ST_ERR_LSB +: sdsu_pkg::ERR_W];
          n.nak_retry_count = reg_bus.wdata[sdsu_pkg::ST_NAK_LSB +: sdsu_pkg::NAK_W];
          n.transferred_byte_count =
            reg_bus.wdata[sdsu_pkg::ST_BYTES_LSB +: sdsu_pkg::BYTES_W];
          n.done = 1'b0;
        end

        // Valid and reload; software retires a descriptor by clearing valid
        sdsu_pkg::OFS_CTRL: begin
          n.valid = reg_bus.wdata[sdsu_pkg::CT_VALID];
          n.nak_reload_value = reg_bus.wdata[sdsu_pkg::CT_RELOAD_LSB +: sdsu_pkg::NAK_W];
        end

        sdsu_pkg::OFS_ENGINE: begin
          // Write one to drop the retry hold early
          if (reg_bus.wdata[sdsu_pkg::EN_RETRY_FIRST]) begin
            n.retry_first = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Hold only lasts until the frame boundary it waits for
    if (sof_in) begin
      n.retry_first = 1'b0;
    end

    if (live_evt) begin
      n.last_result = split_result_code_in;
      n.xact_err = 1'b0;
      // Record what happened, then let the outcome decide each field
      unique case (split_result_code_in)
        // Handshake accepted by the hub
        sdsu_pkg::RES_ACK: begin
          if (!r.split_phase_bit) begin
            // Start split accepted by the hub: complete split goes next
            n.split_phase_bit = 1'b1;
          end else begin
            // Complete split finished the data phase
            n.toggle_bit = ~r.toggle_bit;
            n.transferred_byte_count = split_result_bytes_in;
            n.split_phase_bit = 1'b0;
            n.active = 1'b0;
            n.done = 1'b1;
          end
          // Any handshake from the hub restores the full error budget
          n.err_count = sdsu_pkg::ERR_RELOAD;
        end

        // Hub had no room; only the NAK budget shrinks
        sdsu_pkg::RES_NAK: begin
          n.err_count = sdsu_pkg::ERR_RELOAD;
          // Isochronous splits and a zero reload leave the counter alone
          if (!split_iso_in && (r.nak_reload_value != sdsu_pkg::NAK_ZERO)) begin
            n.nak_retry_count = r.nak_retry_count - sdsu_pkg::NAK_ONE;
            if (r.nak_retry_count <= sdsu_pkg::NAK_ONE) begin
              n.nak_retry_count = sdsu_pkg::NAK_ZERO;
              n.valid = 1'b0;
              n.active = 1'b0;
              n.done = 1'b1;
            end
          end
        end

        // Hub not done yet; the complete split is simply repeated
        sdsu_pkg::RES_NYET: begin
          n.err_count = sdsu_pkg::ERR_RELOAD;
        end

        // No answer or a corrupt one costs one unit of the error budget
        sdsu_pkg::RES_ERR: begin
          n.xact_err = 1'b1;
          n.err_count = r.err_count - sdsu_pkg::ERR_ONE;
          // A counter already at zero counts as exhausted, never wraps
          if (r.err_count <= sdsu_pkg::ERR_ONE) begin
            n.err_count = sdsu_pkg::ERR_ZERO;
            n.valid = 1'b0;
            n.active = 1'b0;
            n.halt = 1'b1;
            n.done = 1'b1;
          end
        end

        // Babble cannot be retried safely, so the descriptor is retired at once
        sdsu_pkg::RES_BABBLE: begin
          n.babble = 1'b1;
          n.halt = 1'b1;
          n.active = 1'b0;
          n.valid = 1'b0;
          n.done = 1'b1;
        end

        // Codes beyond babble are not outcomes and change no field, but still count as failed for the retry hold
        default: begin
          n.last_result = r.last_result;
          n.xact_err = r.xact_err;
        end
      endcase
    end

    // A retry that cannot fit holds the pointer; set beats SOF clear
    if (failed_evt && n.valid && time_short_in) begin
      n.retry_first = 1'b1;
    end
  end

  // State register; descriptor comes out of reset idle and invalid
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // Status flags come up cleared
      r.active <= 1'b0;
      r.halt <= 1'b0;
      r.babble <= 1'b0;
      r.xact_err <= 1'b0;
      r.split_phase_bit <= 1'b0;
      r.toggle_bit <= 1'b0;

      // Error budget reads as full, the value software normally loads
      r.err_count <= sdsu_pkg::ERR_RELOAD;
      r.nak_retry_count <= sdsu_pkg::NAK_ZERO;
      r.transferred_byte_count <= '0;

      // Control word: no descriptor is valid until software says so
      r.valid <= 1'b0;
      r.nak_reload_value <= sdsu_pkg::NAK_ZERO;
      // Engine bookkeeping
      r.retry_first <= 1'b0;
      r.last_result <= sdsu_pkg::RES_ACK;
      r.done <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state flops
  // The scheduler reads these; software sees the same bits in the images
  assign desc_active_out = r.active;
  assign desc_valid_out = r.valid;
  assign split_phase_out = r.split_phase_bit;
  assign toggle_out = r.toggle_bit;
  assign retry_first_out = r.retry_first;
endmodule
`default_nettype wire

// [sim/sdsu_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module sdsu_checker (
  input wire logic core_clk_in, // Core clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic hsel_in, // Select
  input wire logic [1:0] htrans_in, // Transfer type
  input wire logic hwrite_in, // Write
  input wire logic hready_in, // Bus ready
  input wire logic hreadyout_out, // Slave ready
  input wire logic hresp_out, // Response
  input wire logic split_result_valid_in, // Result pulse
  input wire logic [2:0] split_result_code_in, // Result code
  input wire logic split_iso_in, // Isochronous
  input wire logic time_short_in, // Short of time
  input wire logic sof_in, // Frame start
  input wire logic desc_active_out, // Active
  input wire logic desc_valid_out, // Valid
  input wire logic split_phase_out, // Phase
  input wire logic toggle_out, // Toggle
  input wire logic retry_first_out // Retry hold
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Results only count while the descriptor is both valid and active
  logic ev;
  logic [2:0] rc;
  assign ev = split_result_valid_in && desc_valid_out && desc_active_out;
  assign rc = split_result_code_in;
  // Reads take exactly one wait state
  sequence rd_req; hsel_in && hready_in && htrans_in == 2'h2 && !hwrite_in; endsequence
  sequence one_wait; !hreadyout_out ##1 hreadyout_out; endsequence
  a_read_one_wait: assert property (rd_req |=> one_wait) else $error("read wait wrong");
  a_hresp_okay: assert property (hresp_out == 1'b0) else $error("response not okay");
  a_start_to_complete: assert property (ev && rc == 3'h0 && !split_phase_out
    |=> split_phase_out) else $error("phase not advanced");
  a_toggle_on_data: assert property (ev && rc == 3'h0 && split_phase_out |=>
    toggle_out != $past(toggle_out) && !desc_active_out) else $error("toggle wrong");
  a_babble_drops: assert property (ev && rc == 3'h4
    |=> !desc_valid_out && !desc_active_out) else $error("babble kept descriptor");
  a_nyet_keeps_valid: assert property (ev && rc == 3'h2 |=> desc_valid_out)
    else $error("nyet dropped valid");
  a_iso_nak_keeps: assert property (ev && rc == 3'h1 && split_iso_in |=> desc_valid_out)
    else $error("iso nak dropped valid");
  a_retry_set: assert property (ev && rc == 3'h2 && time_short_in |=> retry_first_out)
    else $error("retry hold not set");
  a_retry_sof_clear: assert property (retry_first_out && sof_in && !split_result_valid_in
    |=> !retry_first_out) else $error("retry hold not cleared");
endmodule
bind sdsu_top sdsu_checker u_sdsu_checker (.core_clk_in, .rst_n_in, .hsel_in, .htrans_in,
  .hwrite_in, .hready_in, .hreadyout_out, .hresp_out, .split_result_valid_in,
  .split_result_code_in, .split_iso_in, .time_short_in, .sof_in, .desc_active_out,
  .desc_valid_out, .split_phase_out, .toggle_out, .retry_first_out);
`default_nettype wire

// [sim/sdsu_tt_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sdsu_tt_model (
  input wire logic clk_in, // Core clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic go_in, // Start one split attempt
  input wire logic [19:0] req_in, // Code, bytes, iso, short
  input wire logic [1:0] delay_in, // Extra cycles before answer
  output logic valid_out, // Result pulse
  output logic [19:0] res_out // Fields standing with the pulse
);
  logic busy;
  logic [1:0] cnt;
  logic [19:0] held;
  // Fields are garbage outside the pulse so a late sampler cannot pass
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy <= 1'b0;
      cnt <= 2'h0;
      held <= 20'h0;
      valid_out <= 1'b0;
      res_out <= 20'h0;
    end else if (go_in) begin
      busy <= 1'b1;
      cnt <= delay_in;
      held <= req_in;
      valid_out <= 1'b0;
    end else if (busy && cnt == 2'h0) begin
      busy <= 1'b0;
      valid_out <= 1'b1;
      res_out <= held;
    end else begin
      cnt <= cnt - 2'h1;
      valid_out <= 1'b0;
      res_out <= ~res_out;
    end
  end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [31:0] ST = sdsu_pkg::OFS_STATUS;
  localparam logic [31:0] CT = sdsu_pkg::OFS_CTRL;
  localparam logic [31:0] EN = sdsu_pkg::OFS_ENGINE;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic go = 1'b0;
  logic sof = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [1:0] dly = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [19:0] req = 20'h0;
  logic [31:0] hrdata;
  logic [19:0] res;
  logic hready, hresp, sv, pact, pval, ph, tg, rf, rd_pend, t;
  logic [14:0] b;
  logic [31:0] expq[$];
  int fail_count = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  sdsu_top u_sdsu_top (.core_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .split_result_valid_in(sv), .split_result_code_in(res[19:17]),
    .split_result_bytes_in(res[16:2]), .split_iso_in(res[1]), .time_short_in(res[0]),
    .sof_in(sof), .desc_active_out(pact), .desc_valid_out(pval), .split_phase_out(ph),
    .toggle_out(tg), .retry_first_out(rf));
  sdsu_tt_model u_sdsu_tt_model (.clk_in(clk), .rst_n_in(rst_n), .go_in(go), .req_in(req),
    .delay_in(dly), .valid_out(sv), .res_out(res));
  task automatic conclude;
    if (expq.size() != 0) begin
      fail_count++;
    end
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a level sampled at a rising edge
  task automatic wt(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s !== 1'b1 && n < 64);
    if (n >= 64) begin
      fail_count++;
      conclude();
    end
  endtask
  // One AHB single transfer; hwdata holds for the whole data phase
  task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic w);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wt(hready);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt(hready);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, d, 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expq.push_back(e);
    xfer(a, 32'h0, 1'b0);
  endtask
  // Ask the far side for one attempt and wait until its result is taken
  task automatic ev(input logic [2:0] c, input logic [14:0] y, input logic i, input logic s);
    req <= {c, y, i, s};
    dly <= 2'($urandom_range(0, 3));
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wt(sv);
  endtask
  // Read data is checked at the edge that closes the data phase
  always @(posedge clk) begin
    if (rd_pend && hready === 1'b1 && expq.size() > 0) begin
      rd_pend <= 1'b0;
      cmp32(hrdata, expq.pop_front());
    end
    if (hsel && htrans == 2'h2 && !hwrite && hready === 1'b1) begin
      rd_pend <= 1'b1;
    end
  end
  initial begin
    rd_pend = 1'b0;
    void'($urandom(89));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ST, 32'h0180_0000);
    rd(EN, 32'h0);
    wr(32'h0000_000C, 32'hFFFF_FFFF);
    rd(32'h0000_000C, 32'h0);
    repeat (3) begin
      t = 1'($urandom);
      b = 15'($urandom);
      wr(CT, 32'h1);
      wr(ST, 32'h8180_0000 | (32'(t) << 25));
      ev(3'h0, b, 1'b0, 1'b0);
      @(negedge clk) cmp32({29'h0, pact, pval, ph}, 32'h7);
      @(posedge clk);
      ev(3'h0, b, 1'b0, 1'b0);
      ev(3'h3, 15'h0, 1'b0, 1'b0);
      rd(ST, 32'h0180_0000 | (32'(!t) << 25) | 32'(b));
      rd(EN, 32'h10);
    end
    wr(CT, 32'h1);
    wr(ST, 32'h8180_0000);
    ev(3'h3, 15'h0, 1'b0, 1'b1);
    rd(ST, 32'h9100_0000);
    rd(EN, 32'h7);
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
    rd(EN, 32'h6);
    ev(3'h2, 15'h0, 1'b0, 1'b1);
    rd(ST, 32'h8180_0000);
    rd(EN, 32'h5);
    wr(EN, 32'h1);
    rd(EN, 32'h4);
    repeat (3) ev(3'h3, 15'h0, 1'b0, 1'b0);
    rd(ST, 32'h5000_0000);
    rd(CT, 32'h0);
    wr(CT, 32'h5);
    wr(ST, 32'h8090_0000);
    ev(3'h1, 15'h0, 1'b1, 1'b0);
    rd(ST, 32'h8190_0000);
    repeat (2) ev(3'h1, 15'h0, 1'b0, 1'b0);
    rd(ST, 32'h0180_0000);
    rd(CT, 32'h4);
    wr(CT, 32'h1);
    wr(ST, 32'h8088_0000);
    ev(3'h1, 15'h0, 1'b0, 1'b0);
    rd(ST, 32'h8188_0000);
    ev(3'h4, 15'h0, 1'b0, 1'b0);
    rd(ST, 32'h6188_0000);
    rd(CT, 32'h0);
    @(negedge clk) cmp32({26'h0, hresp, pact, pval, ph, tg, rf}, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
